// file: verilog/ccc_defines.svh
// Constants for the counter clock control block: offsets, fields, reset values.
// Assumes inclusion by bare name from the top-level design file.
`ifndef CCC_DEFINES_SVH
`define CCC_DEFINES_SVH
`define CCC_ADDR_CTRL      8'h00
`define CCC_ADDR_COUNT     8'h04
`define CCC_ADDR_STATUS    8'h08
`define CCC_ADDR_MASK      8'h0C
`define CCC_CTRL_RESET     8'h00
`define CCC_CTRL_WMASK     8'hFD
`define CCC_BIT_ON         0
`define CCC_BIT_SYNC_DIS   2
`define CCC_BIT_OSC_EN     3
`define CCC_PS_LSB         4
`define CCC_CS_LSB         6
`define CCC_INSTR_DIV      2'h3
`define CCC_RESP_OKAY      2'h0
`define CCC_RESP_SLVERR    2'h2
`endif

// file: verilog/ccc_pkg.sv
// Types for the counter clock control block.
// Assumes the defines header is available on the include path.
package ccc_pkg;
    // Count source selection codes.
    typedef enum logic [1:0] {
        CCC_SRC_INSTR = 2'h0,
        CCC_SRC_SYS   = 2'h1,
        CCC_SRC_EXT   = 2'h2,
        CCC_SRC_RSVD  = 2'h3
    } ccc_src_e;
endpackage

// file: verilog/ccc_sync.sv
// Two-stage synchroniser for one external level.
// Assumes a single system clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ccc_sync (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_reg;
    logic sync_reg;
    // Second stage alone reads the first stage.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end
    assign sync_out = sync_reg;
endmodule
`default_nettype wire

// file: verilog/ccc_prescale.sv
// Input prescaler: passes one of every 1, 2, 4 or 8 count ticks.
// Assumes ticks are single-cycle pulses on the system clock.
`timescale 1ns/1ps
`default_nettype none
module ccc_prescale (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       clr,
    input  wire logic [1:0] sel,
    input  wire logic       tick_in,
    output logic            tick_out
);
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [2:0] lim;
    // Terminal count per code; a count left above a lowered limit passes at once.
    always_comb begin
        lim = 3'((4'h1 << sel) - 4'h1);
        cnt_next = cnt_reg;
        if (clr) begin
            cnt_next = 3'h0;
        end else if (tick_in) begin
            cnt_next = (cnt_reg >= lim) ? 3'h0 : cnt_reg + 3'h1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    assign tick_out = tick_in && !clr && (cnt_reg >= lim);
endmodule
`default_nettype wire

// file: verilog/ccc_top.sv
// Counter clock control: control register, source mux, prescaler, 16-bit count.
// Assumes an AXI4-Lite master on aclk; external pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "ccc_defines.svh"
module ccc_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        por_bor_n,
    input  wire logic        sleep_mode,
    input  wire logic        ext_count_pin,
    input  wire logic        crystal_in_pin,
    output logic             crystal_out_pin,
    output logic             low_power_osc_run,
    output logic             gate_ff_clear,
    output logic             counter_on,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic        stat_reg;
    logic        stat_next;
    logic        mask_reg;
    logic        mask_next;
    logic        aw_reg;
    logic        aw_next;
    logic [7:0]  awa_reg;
    logic [7:0]  awa_next;
    logic        w_reg;
    logic        w_next;
    logic [31:0] wd_reg;
    logic [31:0] wd_next;
    logic [3:0]  ws_reg;
    logic [3:0]  ws_next;
    logic        bv_reg;
    logic        bv_next;
    logic [1:0]  br_reg;
    logic [1:0]  br_next;
    logic        rv_reg;
    logic        rv_next;
    logic [31:0] rd_reg;
    logic [31:0] rd_next;
    logic [1:0]  rr_reg;
    logic [1:0]  rr_next;
    logic [1:0]  idiv_reg;
    logic [1:0]  idiv_next;
    logic        ext_prev_reg;
    logic        ext_prev_next;
    logic        async_prev_reg;
    logic        async_prev_next;

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    ccc_pkg::ccc_src_e src;
    logic ext_raw;
    logic ext_sync;
    logic sync_dis;
    logic ext_sel;
    logic tick_src;
    logic tick_pre;
    logic wrap;
    logic do_write;

    // External input: crystal when the oscillator is on, otherwise the pin.
    assign src      = ccc_pkg::ccc_src_e'(ctrl_reg[`CCC_CS_LSB+:2]);
    assign ext_raw  = ctrl_reg[`CCC_BIT_OSC_EN] ? crystal_in_pin : ext_count_pin;
    assign sync_dis = ctrl_reg[`CCC_BIT_SYNC_DIS];
    assign ext_sel  = src == ccc_pkg::CCC_SRC_EXT;

    ccc_sync u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (ext_raw),
        .sync_out (ext_sync)
    );

    // Tick per source; the unsynchronised path samples the pin directly.
    always_comb begin
        tick_src = 1'b0;
        case (src)
            ccc_pkg::CCC_SRC_INSTR: tick_src = idiv_reg == `CCC_INSTR_DIV;
            ccc_pkg::CCC_SRC_SYS:   tick_src = 1'b1;
            ccc_pkg::CCC_SRC_EXT: begin
                if (sync_dis) begin
                    tick_src = ext_raw && !async_prev_reg;
                end else begin
                    tick_src = ext_sync && !ext_prev_reg;
                end
            end
            default: tick_src = 1'b0;
        endcase
        // Only asynchronous external counting runs in sleep.
        if (sleep_mode && !(ext_sel && sync_dis)) begin
            tick_src = 1'b0;
        end
    end

    ccc_prescale u_pre (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clr      (!ctrl_reg[`CCC_BIT_ON]),
        .sel      (ctrl_reg[`CCC_PS_LSB+:2]),
        .tick_in  (tick_src),
        .tick_out (tick_pre)
    );

    assign wrap     = ctrl_reg[`CCC_BIT_ON] && tick_pre && count_reg == 16'hFFFF;
    assign do_write = aw_reg && w_reg && !bv_reg;

    // ------------------------------------------------------------
    // Next-state logic for counter, control, and bus
    // ------------------------------------------------------------
    always_comb begin
        idiv_next       = idiv_reg + 2'h1;
        ext_prev_next   = ext_sync;
        async_prev_next = ext_raw;
        count_next      = count_reg;
        ctrl_next       = ctrl_reg;
        stat_next       = stat_reg;
        mask_next       = mask_reg;
        aw_next  = aw_reg;
        awa_next = awa_reg;
        w_next   = w_reg;
        wd_next  = wd_reg;
        ws_next  = ws_reg;
        bv_next  = bv_reg;
        br_next  = br_reg;
        rv_next  = rv_reg;
        rd_next  = rd_reg;
        rr_next  = rr_reg;
        if (ctrl_reg[`CCC_BIT_ON] && tick_pre) begin
            count_next = count_reg + 16'h0001;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            aw_next  = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_next  = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
        end
        if (do_write) begin
            aw_next = 1'b0;
            w_next  = 1'b0;
            bv_next = 1'b1;
            br_next = `CCC_RESP_OKAY;
            if (awa_reg == `CCC_ADDR_CTRL) begin
                if (ws_reg[0]) begin
                    ctrl_next = wd_reg[7:0] & `CCC_CTRL_WMASK;
                end
            end else if (awa_reg == `CCC_ADDR_COUNT) begin
                if (ws_reg[0]) begin
                    count_next[7:0] = wd_reg[7:0];
                end
                if (ws_reg[1]) begin
                    count_next[15:8] = wd_reg[15:8];
                end
            end else if (awa_reg == `CCC_ADDR_STATUS) begin
                if (ws_reg[0] && wd_reg[0]) begin
                    stat_next = 1'b0;
                end
            end else if (awa_reg == `CCC_ADDR_MASK) begin
                if (ws_reg[0]) begin
                    mask_next = wd_reg[0];
                end
            end else begin
                br_next = `CCC_RESP_SLVERR;
            end
        end
        // Rollover set wins over a same-cycle clear.
        if (wrap) begin
            stat_next = 1'b1;
        end
        if (bv_reg && s_axi_bready) begin
            bv_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_next = 1'b1;
            rr_next = `CCC_RESP_OKAY;
            rd_next = 32'h0000_0000;
            if (s_axi_araddr == `CCC_ADDR_CTRL) begin
                rd_next[7:0] = ctrl_reg;
            end else if (s_axi_araddr == `CCC_ADDR_COUNT) begin
                rd_next[15:0] = count_reg;
            end else if (s_axi_araddr == `CCC_ADDR_STATUS) begin
                rd_next[0] = stat_reg;
            end else if (s_axi_araddr == `CCC_ADDR_MASK) begin
                rd_next[0] = mask_reg;
            end else begin
                rr_next = `CCC_RESP_SLVERR;
            end
        end else if (rv_reg && s_axi_rready) begin
            rv_next = 1'b0;
        end
    end

    // Control register clears only on power-on or brown-out reset.
    always_ff @(posedge aclk) begin
        if (!por_bor_n) begin
            ctrl_reg <= `CCC_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Remaining state follows the system reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg      <= 16'h0000;
            stat_reg       <= 1'b0;
            mask_reg       <= 1'b0;
            aw_reg         <= 1'b0;
            awa_reg        <= 8'h00;
            w_reg          <= 1'b0;
            wd_reg         <= 32'h0000_0000;
            ws_reg         <= 4'h0;
            bv_reg         <= 1'b0;
            br_reg         <= 2'h0;
            rv_reg         <= 1'b0;
            rd_reg         <= 32'h0000_0000;
            rr_reg         <= 2'h0;
            idiv_reg       <= 2'h0;
            ext_prev_reg   <= 1'b0;
            async_prev_reg <= 1'b0;
        end else begin
            count_reg      <= count_next;
            stat_reg       <= stat_next;
            mask_reg       <= mask_next;
            aw_reg         <= aw_next;
            awa_reg        <= awa_next;
            w_reg          <= w_next;
            wd_reg         <= wd_next;
            ws_reg         <= ws_next;
            bv_reg         <= bv_next;
            br_reg         <= br_next;
            rv_reg         <= rv_next;
            rd_reg         <= rd_next;
            rr_reg         <= rr_next;
            idiv_reg       <= idiv_next;
            ext_prev_reg   <= ext_prev_next;
            async_prev_reg <= async_prev_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready     = !aw_reg && !bv_reg;
    assign s_axi_wready      = !w_reg && !bv_reg;
    assign s_axi_bvalid      = bv_reg;
    assign s_axi_bresp       = br_reg;
    assign s_axi_arready     = !rv_reg;
    assign s_axi_rvalid      = rv_reg;
    assign s_axi_rdata       = rd_reg;
    assign s_axi_rresp       = rr_reg;
    assign irq               = stat_reg && mask_reg;
    assign counter_on        = ctrl_reg[`CCC_BIT_ON];
    assign gate_ff_clear     = !ctrl_reg[`CCC_BIT_ON];
    // Oscillator keeps running in sleep regardless of the sync setting.
    assign low_power_osc_run = ctrl_reg[`CCC_BIT_OSC_EN];
    assign crystal_out_pin   = ctrl_reg[`CCC_BIT_OSC_EN] && !crystal_in_pin;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_wrap_flag;
        @(posedge aclk) disable iff (!aresetn) wrap |=> stat_reg;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("rollover flag missed");

    property p_wrap_zero;
        @(posedge aclk) disable iff (!aresetn) (wrap && !do_write) |=> count_reg == 16'h0000;
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("count did not wrap");

    property p_bit1_zero;
        @(posedge aclk) disable iff (!aresetn) ctrl_reg[1] == 1'b0;
    endproperty
    a_bit1_zero: assert property (p_bit1_zero) else $error("bit one set");

    property p_off_hold;
        @(posedge aclk) disable iff (!aresetn)
            (!ctrl_reg[`CCC_BIT_ON] && !do_write) |=> $stable(count_reg);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("count moved while off");

    property p_sleep_stop;
        @(posedge aclk) disable iff (!aresetn)
            (sleep_mode && !(ext_sel && sync_dis) && !do_write) |=> $stable(count_reg);
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("counted in sleep");

    property p_div1;
        @(posedge aclk) disable iff (!aresetn)
            (ctrl_reg[`CCC_BIT_ON] && ctrl_reg[5:4] == 2'h0) |-> tick_pre == tick_src;
    endproperty
    a_div1: assert property (p_div1) else $error("prescale 1 wrong");

    property p_sys_run;
        @(posedge aclk) disable iff (!aresetn)
            (src == ccc_pkg::CCC_SRC_SYS && !sleep_mode) |-> tick_src;
    endproperty
    a_sys_run: assert property (p_sys_run) else $error("system clock tick missing");

    property p_rsvd;
        @(posedge aclk) disable iff (!aresetn) src == ccc_pkg::CCC_SRC_RSVD |-> !tick_src;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved source counted");

    property p_por;
        @(posedge aclk) !por_bor_n |=> ctrl_reg == 8'h00;
    endproperty
    a_por: assert property (p_por) else $error("control not cleared");
endmodule
`default_nettype wire

// file: tb/ccc_pin_model.sv
// External count source model: a count pin and a low-power crystal.
// Assumes the design drives crystal_out_pin only while the oscillator is on.
`timescale 1ns/1ps
`default_nettype none
module ccc_pin_model (
    input  wire logic       aclk,
    input  wire logic       pin_run,
    input  wire logic [7:0] pin_half,
    input  wire logic       crystal_out_pin,
    output logic            ext_count_pin,
    output var logic        crystal_in_pin
);
    logic [7:0] half_cnt;

    // The pin toggles every pin_half clocks while running, else it rests low on its pull-down.
    initial ext_count_pin = 1'b0;
    initial half_cnt = 8'h00;
    always @(posedge aclk) begin
        if (!pin_run) begin
            ext_count_pin <= 1'b0;
            half_cnt <= 8'h00;
        end else if (half_cnt >= pin_half - 8'h01) begin
            ext_count_pin <= !ext_count_pin;
            half_cnt <= 8'h00;
        end else begin
            half_cnt <= half_cnt + 8'h01;
        end
    end

    // The crystal returns the drive 100 ns late, so the loop rings with a 200 ns period.
    initial crystal_in_pin = 1'b0;
    always @(crystal_out_pin) begin
        crystal_in_pin <= #100 crystal_out_pin;
    end
endmodule
`default_nettype wire

// file: tb/test_counter_clock_control.sv
// Self-checking bench for the counter clock control block over AXI4-Lite.
// Assumes ccc_top and ccc_pin_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_counter_clock_control;
    logic        aclk, aresetn, por_bor_n, sleep_mode, pin_run;
    logic        ext_count_pin, crystal_in_pin, crystal_out_pin;
    logic        low_power_osc_run, gate_ff_clear, counter_on, irq;
    logic [7:0]  pin_half, awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, base, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    int          n_fail, checked, cycles;

    ccc_top dut (.aclk(aclk), .aresetn(aresetn), .por_bor_n(por_bor_n), .sleep_mode(sleep_mode),
        .ext_count_pin(ext_count_pin), .crystal_in_pin(crystal_in_pin),
        .crystal_out_pin(crystal_out_pin), .low_power_osc_run(low_power_osc_run),
        .gate_ff_clear(gate_ff_clear), .counter_on(counter_on), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq));

    ccc_pin_model partner (.aclk(aclk), .pin_run(pin_run), .pin_half(pin_half),
        .crystal_out_pin(crystal_out_pin), .ext_count_pin(ext_count_pin),
        .crystal_in_pin(crystal_in_pin));

    // ----------------------------------------------------------------
    // Clock, timeout and reporting
    // ----------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #10 aclk = !aclk;
    end

    // A hung handshake ends the run as a failure.
    initial cycles = 0;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            test_done();
        end
    end

    task automatic test_done();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // ----------------------------------------------------------------
    // Bus tasks: each channel is released at the edge where it is taken
    // ----------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            if (tb) r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end while (!tb);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            if (tr) d = rdata;
            if (tr) r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end while (!tr);
    endtask

    // Counts over a fixed window; d<0 records the base rate, d=0 expects a frozen count.
    task automatic meas(input logic [7:0] c, input int d);
        logic [31:0] c0, c1, dl;
        logic [1:0]  r;
        axi_wr(8'h00, {24'h0, c}, r);
        repeat (8) @(posedge aclk);
        axi_rd(8'h04, c0, r);
        repeat (256) @(posedge aclk);
        axi_rd(8'h04, c1, r);
        dl = (c1 - c0) & 32'h0000FFFF;
        if (d < 0) base = dl;
        else if (d == 0) chk(dl, 32'h0);
        else chk({31'h0, (dl * d + 2 * d >= base) && (dl * d <= base + 2 * d)}, 32'h1);
    endtask

    task automatic pulse(input logic por);
        @(posedge aclk);
        if (por) por_bor_n <= 1'b0;
        else aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        por_bor_n <= 1'b1;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {aresetn, por_bor_n, sleep_mode, pin_run, awvalid, wvalid, bready} = 7'h00;
        {arvalid, rready, awaddr, araddr, wdata, wstrb} = 54'h0;
        pin_half = 8'h05;
        n_fail = 0;
        checked = 0;
        base = 32'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        por_bor_n <= 1'b1;
        axi_rd(8'h00, rd, rs);
        chk(rd, 32'h0);
        chk({30'h0, rs}, 32'h0);
        axi_wr(8'h00, 32'hFF, rs);
        chk({30'h0, rs}, 32'h0);
        axi_rd(8'h00, rd, rs);
        chk(rd, 32'hFD);
        chk({31'h0, counter_on}, 32'h1);
        pulse(1'b0);
        axi_rd(8'h00, rd, rs);
        chk(rd, 32'hFD);
        pulse(1'b1);
        axi_rd(8'h00, rd, rs);
        chk(rd, 32'h0);
        chk({29'h0, crystal_out_pin, low_power_osc_run, gate_ff_clear}, 32'h1);
        axi_rd(8'h10, rd, rs);
        chk({rs, rd[29:0]}, 32'h80000000);
        axi_wr(8'h10, 32'h1, rs);
        chk({30'h0, rs}, 32'h2);
        // Rates of every source and prescale code against the system clock.
        meas(8'h41, -1);
        chk({31'h0, base >= 32'h100 && base <= 32'h12C}, 32'h1);
        meas(8'h51, 2);
        meas(8'h61, 4);
        meas(8'h71, 8);
        meas(8'h01, 4);
        meas(8'h05, 4);
        meas(8'h45, 1);
        meas(8'hC1, 0);
        meas(8'h40, 0);
        pin_run <= 1'b1;
        meas(8'h81, 10);
        meas(8'h85, 10);
        meas(8'h91, 20);
        sleep_mode <= 1'b1;
        meas(8'h85, 10);
        meas(8'h81, 0);
        meas(8'h41, 0);
        pin_run <= 1'b0;
        meas(8'h89, 0);
        chk({31'h0, low_power_osc_run}, 32'h1);
        meas(8'h8D, 10);
        sleep_mode <= 1'b0;
        meas(8'h89, 10);
        // Wrap from the top of the count raises the flag and the interrupt.
        axi_wr(8'h00, 32'h40, rs);
        axi_wr(8'h04, 32'hFFF0, rs);
        axi_rd(8'h04, rd, rs);
        chk(rd, 32'hFFF0);
        axi_rd(8'h08, rd, rs);
        chk(rd, 32'h0);
        axi_wr(8'h0C, 32'h1, rs);
        axi_wr(8'h00, 32'h41, rs);
        repeat (40) @(posedge aclk);
        axi_wr(8'h00, 32'h40, rs);
        axi_rd(8'h04, rd, rs);
        chk({31'h0, rd < 32'h40}, 32'h1);
        axi_rd(8'h08, rd, rs);
        chk(rd, 32'h1);
        chk({30'h0, irq, gate_ff_clear}, 32'h3);
        axi_wr(8'h0C, 32'h0, rs);
        chk({31'h0, irq}, 32'h0);
        axi_wr(8'h0C, 32'h1, rs);
        chk({31'h0, irq}, 32'h1);
        axi_wr(8'h08, 32'h1, rs);
        axi_rd(8'h08, rd, rs);
        chk(rd, 32'h0);
        chk({31'h0, irq}, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
